// ### shared/fsfs_consts.svh
// fault status flag slice: offsets, bit positions, reset values
// assumes inclusion by bare name from design files
`ifndef FSFS_CONSTS_SVH
`define FSFS_CONSTS_SVH
`define FSFS_OFF_STATUS 12'h000
`define FSFS_OFF_MEM_FAULT_ADDRESS_REG 12'h004
`define FSFS_OFF_BFADDR 12'h008
`define FSFS_OFF_SP 12'h00c
`define FSFS_OFF_IRQ_STAT 12'h010
`define FSFS_OFF_IRQ_CLR 12'h014
`define FSFS_OFF_IRQ_EN 12'h018
`define FSFS_BIT_INSTR_BUS_ERR_FLAG 8
`define FSFS_BIT_MEM_FAULT_ADDR_VALID 7
`define FSFS_BIT_RSV_HI 6
`define FSFS_BIT_RSV_LO 5
`define FSFS_BIT_STK 4
`define FSFS_RST_FLAGS 32'h0000_0000
`define FSFS_RST_WORD 32'h0000_0000
`define FSFS_STK_FRAME 32'h0000_0020
`define FSFS_IRQ_INSTR_BUS_ERR_FLAG 0
`define FSFS_IRQ_STK 1
`define FSFS_IRQ_DACC 2
`define FSFS_IRQ_W 3
`endif

// ### shared/fsfs_pkg.sv
// fault status flag slice: shared types
// assumes nothing beyond the consts header
package fsfs_pkg;
	typedef enum logic [1:0] {FSFS_IDLE, FSFS_SETUP, FSFS_DONE} fsfs_apb_st_t;
	typedef logic [31:0] fsfs_word_t;
endpackage : fsfs_pkg

// ### design/fsfs_w1c_flag.sv
// one sticky flag, set by hardware, cleared by writing one
// assumes set and clear are single-cycle qualified strobes
`timescale 1ns/10ps
module fsfs_w1c_flag
	import fsfs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic set_i,
	input wire logic clr_i,
	output logic flag_q
);
	// set beats clear so an event in the clear cycle is kept
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_q <= 1'b0;
		else if (set_i)
			flag_q <= 1'b1;
		else if (clr_i)
			flag_q <= 1'b0;
	end

	a_set_holds: assert property (@(posedge pclk) disable iff (!presetn)
		set_i |=> flag_q)
		else $error("flag did not set after event");
	a_hold_no_clr: assert property (@(posedge pclk) disable iff (!presetn)
		(flag_q && !clr_i) |=> flag_q)
		else $error("flag dropped without a clear");
endmodule : fsfs_w1c_flag

// ### design/fsfs_slice.sv
// fault status flag slice: sticky fault flags, address capture, apb slave
// assumes core fault strobes are one-cycle pulses synchronous to pclk
// What this block does
// - the instruction bus error flag sits at bit 8 and reads 1 once such an error happened.
// - a prefetch bus error sets the flag only when the faulting instruction is issued.
// - an instruction bus error leaves the bus fault address register untouched.
// - each flag clears only on a write of one to its bit, a zero write leaves it.
// - the address valid flag at bit 7 says the memory fault address register is valid.
// - bits 6:5 are reserved, read only and read zero.
// - the stack access violation flag at bit 4 sets when exception entry stacking faults.
// - on a stacking violation the stack pointer still moves and no fault address is caught.
// - a data access violation captures its address into the memory fault address register.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
`include "fsfs_consts.svh"
module fsfs_slice
	import fsfs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic instr_bus_err_flag_err_prefetch,
	input wire logic instr_issue,
	input wire logic precise_bus_err,
	input wire logic [31:0] bus_err_addr,
	input wire logic stack_violation,
	input wire logic data_violation,
	input wire logic [31:0] data_viol_addr,
	input wire logic exc_entry,
	output logic instr_bus_err_flag,
	output logic mem_fault_addr_valid,
	output logic stacking_access_violation,
	output logic [31:0] mem_fault_address_reg,
	output logic [31:0] bus_fault_address_reg,
	output logic [31:0] stack_pointer,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////
	// bus decode
	fsfs_apb_st_t st_q;
	logic acc;
	logic wr;
	logic pend_q;
	logic instr_bus_err_flag_set;
	logic stk_set;
	logic mem_fault_addr_valid_set;
	logic [`FSFS_IRQ_W-1:0] ev;
	logic [`FSFS_IRQ_W-1:0] irq_stat_q;
	logic [`FSFS_IRQ_W-1:0] irq_en_q;
	logic f_instr_bus_err_flag;
	logic f_mem_fault_addr_valid;
	logic f_stk;
	logic irq_any;
	fsfs_word_t status_word;

	function automatic logic w1c(input logic [11:0] a, input logic [11:0] off,
		input logic [31:0] d, input int b, input logic w);
		w1c = w && (a == off) && d[b];
	endfunction : w1c

	// register map decode, shared by the interrupt clear and enable write strobes and the checks
	function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
		reg_hit = (a == off);
	endfunction : reg_hit

	// an offset outside this list answers with an error and reads zero
	function automatic logic mapped(input logic [11:0] a);
		mapped = reg_hit(a, `FSFS_OFF_STATUS) || reg_hit(a, `FSFS_OFF_MEM_FAULT_ADDRESS_REG) ||
			reg_hit(a, `FSFS_OFF_BFADDR) || reg_hit(a, `FSFS_OFF_SP) ||
			reg_hit(a, `FSFS_OFF_IRQ_STAT) || reg_hit(a, `FSFS_OFF_IRQ_CLR) ||
			reg_hit(a, `FSFS_OFF_IRQ_EN);
	endfunction : mapped

	// access taken once, in the first access cycle; ready follows one edge later
	assign acc = psel && penable && (st_q == FSFS_SETUP);
	// writes land only at the edge where ready is seen high, as the master expects
	assign wr = psel && penable && pready && pwrite;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= FSFS_IDLE;
		else
		begin
			case (st_q)
				FSFS_IDLE: st_q <= (psel && !penable) ? FSFS_SETUP : FSFS_IDLE;
				FSFS_SETUP: st_q <= acc ? FSFS_DONE : FSFS_SETUP;
				FSFS_DONE: st_q <= FSFS_IDLE;
				default: st_q <= FSFS_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fault event qualification
	// prefetch error is remembered, flagged only if that instruction issues
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend_q <= 1'b0;
		else if (instr_issue)
			pend_q <= 1'b0;
		else if (instr_bus_err_flag_err_prefetch)
			pend_q <= 1'b1;
	end
	assign instr_bus_err_flag_set = instr_issue && (pend_q || instr_bus_err_flag_err_prefetch);
	assign stk_set = stack_violation;
	// a violation in the stacking cycle captures nothing, so no valid address
	assign mem_fault_addr_valid_set = data_violation && !stack_violation;

	fsfs_w1c_flag u_instr_bus_err_flag (
		.pclk(pclk),
		.presetn(presetn),
		.set_i(instr_bus_err_flag_set),
		.clr_i(w1c(paddr, `FSFS_OFF_STATUS, pwdata, `FSFS_BIT_INSTR_BUS_ERR_FLAG, wr)),
		.flag_q(f_instr_bus_err_flag)
	);
	fsfs_w1c_flag u_mem_fault_addr_valid (
		.pclk(pclk),
		.presetn(presetn),
		.set_i(mem_fault_addr_valid_set),
		.clr_i(w1c(paddr, `FSFS_OFF_STATUS, pwdata, `FSFS_BIT_MEM_FAULT_ADDR_VALID, wr)),
		.flag_q(f_mem_fault_addr_valid)
	);
	fsfs_w1c_flag u_stk (
		.pclk(pclk),
		.presetn(presetn),
		.set_i(stk_set),
		.clr_i(w1c(paddr, `FSFS_OFF_STATUS, pwdata, `FSFS_BIT_STK, wr)),
		.flag_q(f_stk)
	);

	// reserved bits tied to zero
	always_comb
	begin
		status_word = `FSFS_RST_WORD;
		status_word[`FSFS_BIT_INSTR_BUS_ERR_FLAG] = f_instr_bus_err_flag;
		status_word[`FSFS_BIT_MEM_FAULT_ADDR_VALID] = f_mem_fault_addr_valid;
		status_word[`FSFS_BIT_RSV_HI:`FSFS_BIT_RSV_LO] = 2'h0;
		status_word[`FSFS_BIT_STK] = f_stk;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			instr_bus_err_flag <= 1'b0;
			mem_fault_addr_valid <= 1'b0;
			stacking_access_violation <= 1'b0;
		end
		else
		begin
			instr_bus_err_flag <= f_instr_bus_err_flag;
			mem_fault_addr_valid <= f_mem_fault_addr_valid;
			stacking_access_violation <= f_stk;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// address capture and stack pointer
	// only data violations write the memory fault address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mem_fault_address_reg <= `FSFS_RST_WORD;
		else if (data_violation && !stack_violation)
			mem_fault_address_reg <= data_viol_addr;
	end

	// instruction bus errors never load this register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bus_fault_address_reg <= `FSFS_RST_WORD;
		else if (precise_bus_err)
			bus_fault_address_reg <= bus_err_addr;
	end

	// entry always pushes a frame, even when stacking faulted
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stack_pointer <= `FSFS_RST_WORD;
		else if (exc_entry)
			stack_pointer <= stack_pointer - `FSFS_STK_FRAME;
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status, enable and clear
	assign ev = {data_violation, stk_set, instr_bus_err_flag_set};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_stat_q <= '0;
		else if (wr && reg_hit(paddr, `FSFS_OFF_IRQ_CLR))
			irq_stat_q <= (irq_stat_q & ~pwdata[`FSFS_IRQ_W-1:0]) | ev;
		else
			irq_stat_q <= irq_stat_q | ev;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_en_q <= '0;
		else if (wr && reg_hit(paddr, `FSFS_OFF_IRQ_EN))
			irq_en_q <= pwdata[`FSFS_IRQ_W-1:0];
	end

	// an AND-OR of status and enable feeds the output flop, which keeps the line glitch free
	assign irq_any = |(irq_stat_q & irq_en_q);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= irq_any;
	end

	////////////////////////////////////////////////////////////////////////////
	// read data and response
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= `FSFS_RST_WORD;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= acc;
			pslverr <= 1'b0;
			prdata <= `FSFS_RST_WORD;
			if (acc)
			begin
				case (paddr)
					`FSFS_OFF_STATUS: prdata <= status_word;
					`FSFS_OFF_MEM_FAULT_ADDRESS_REG: prdata <= mem_fault_address_reg;
					`FSFS_OFF_BFADDR: prdata <= bus_fault_address_reg;
					`FSFS_OFF_SP: prdata <= stack_pointer;
					`FSFS_OFF_IRQ_STAT: prdata <= {29'h0, irq_stat_q};
					`FSFS_OFF_IRQ_CLR: prdata <= `FSFS_RST_WORD;
					`FSFS_OFF_IRQ_EN: prdata <= {29'h0, irq_en_q};
					default: pslverr <= 1'b1; // unmapped answers with error
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	a_instr_bus_err_flag_issue: assert property (@(posedge pclk) disable iff (!presetn)
		(!f_instr_bus_err_flag && !instr_bus_err_flag_set) |=> !f_instr_bus_err_flag)
		else $error("instruction bus flag set without issue");
	a_instr_bus_err_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
		instr_bus_err_flag_set |-> ##2 instr_bus_err_flag)
		else $error("instruction bus flag missing");
	a_bfar_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(instr_bus_err_flag_set && !precise_bus_err) |=> $stable(bus_fault_address_reg))
		else $error("bus fault address changed on instruction error");
	a_zero_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == `FSFS_OFF_STATUS && !pwdata[`FSFS_BIT_STK] && f_stk)
		|=> f_stk)
		else $error("zero write cleared stack flag");
	a_mem_fault_addr_valid_cap: assert property (@(posedge pclk) disable iff (!presetn)
		(data_violation && !stack_violation)
		|=> f_mem_fault_addr_valid && mem_fault_address_reg == $past(data_viol_addr))
		else $error("fault address not captured");
	a_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(pready && $past(paddr) == `FSFS_OFF_STATUS) |-> prdata[6:5] == 2'h0)
		else $error("reserved bits not zero");
	a_stk_flag: assert property (@(posedge pclk) disable iff (!presetn)
		stack_violation |-> ##2 stacking_access_violation)
		else $error("stack violation flag missing");
	a_stk_noaddr: assert property (@(posedge pclk) disable iff (!presetn)
		stack_violation |=> $stable(mem_fault_address_reg))
		else $error("address captured on stacking fault");
	a_sp_moves: assert property (@(posedge pclk) disable iff (!presetn)
		exc_entry |=> stack_pointer == $past(stack_pointer) - `FSFS_STK_FRAME)
		else $error("stack pointer not adjusted");
	a_mem_fault_addr_valid_clr: assert property (@(posedge pclk) disable iff (!presetn)
		(w1c(paddr, `FSFS_OFF_STATUS, pwdata, `FSFS_BIT_MEM_FAULT_ADDR_VALID, wr) && !data_violation)
		|=> !f_mem_fault_addr_valid)
		else $error("address valid flag not cleared");

	////////////////////////////////////////////////////////////////////////////
	// bus handshake checks
	a_ready_after_acc: assert property (@(posedge pclk) disable iff (!presetn)
		acc |=> pready)
		else $error("ready missing after access");
	a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == `FSFS_RST_WORD)
		else $error("read data not zero outside ready");
	a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && !mapped(paddr)) |=> pslverr && prdata == `FSFS_RST_WORD)
		else $error("unmapped access without error");
	a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && mapped(paddr)) |=> !pslverr)
		else $error("mapped access answered with error");
	a_mem_fault_address_reg_read: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && !pwrite && reg_hit(paddr, `FSFS_OFF_MEM_FAULT_ADDRESS_REG))
		|=> prdata == $past(mem_fault_address_reg))
		else $error("fault address read back wrong");

	////////////////////////////////////////////////////////////////////////////
	// pending prefetch error and address registers
	a_pend_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(instr_bus_err_flag_err_prefetch && !instr_issue) |=> pend_q)
		else $error("prefetch error not held pending");
	a_pend_drop: assert property (@(posedge pclk) disable iff (!presetn)
		instr_issue |=> !pend_q)
		else $error("pending prefetch error kept after issue");
	a_bfar_load: assert property (@(posedge pclk) disable iff (!presetn)
		precise_bus_err |=> bus_fault_address_reg == $past(bus_err_addr))
		else $error("bus fault address not loaded");
	a_sp_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!exc_entry |=> $stable(stack_pointer))
		else $error("stack pointer moved without entry");

	// flags and their registered copies
	a_mem_fault_addr_valid_stack: assert property (@(posedge pclk) disable iff (!presetn)
		(stack_violation && !f_mem_fault_addr_valid) |=> !f_mem_fault_addr_valid)
		else $error("address valid set without a captured address");
	a_stk_set: assert property (@(posedge pclk) disable iff (!presetn)
		stk_set |=> f_stk)
		else $error("stack flag not set");
	a_copy_mem_fault_addr_valid: assert property (@(posedge pclk) disable iff (!presetn)
		f_mem_fault_addr_valid |=> mem_fault_addr_valid)
		else $error("address valid output lags its flag");
	a_copy_stk: assert property (@(posedge pclk) disable iff (!presetn)
		f_stk |=> stacking_access_violation)
		else $error("stack output lags its flag");

	// interrupt line follows enabled status one edge later
	a_irq_on: assert property (@(posedge pclk) disable iff (!presetn)
		irq_any |=> irq)
		else $error("interrupt line not raised");
	a_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
		!irq_any |=> !irq)
		else $error("interrupt line not dropped");
	a_dacc_stat: assert property (@(posedge pclk) disable iff (!presetn)
		ev[`FSFS_IRQ_DACC] |=> irq_stat_q[`FSFS_IRQ_DACC])
		else $error("data violation status not set");
endmodule : fsfs_slice

// ### bench/fsfs_core_model.sv
// core fault detection model: turns a request mask, one bit per fault line, into fault pulses
// assumes the bench raises each request mask for one pclk cycle
`timescale 1ns/10ps
module fsfs_core_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [5:0] req,
	input wire logic [31:0] addr,
	output logic instr_bus_err_flag_err_prefetch,
	output logic instr_issue,
	output logic precise_bus_err,
	output logic stack_violation,
	output logic data_violation,
	output logic exc_entry,
	output logic [31:0] bus_err_addr,
	output logic [31:0] data_viol_addr
);
	////////////////////////////////////////////////////////////////
	// pulses; address lines toggle when unqualified so stale data never looks valid
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{exc_entry, data_violation, stack_violation} <= 3'h0;
			{precise_bus_err, instr_issue, instr_bus_err_flag_err_prefetch} <= 3'h0;
			bus_err_addr <= 32'h0;
			data_viol_addr <= 32'h0;
		end
		else
		begin
			{exc_entry, data_violation, stack_violation} <= req[5:3];
			{precise_bus_err, instr_issue, instr_bus_err_flag_err_prefetch} <= req[2:0];
			bus_err_addr <= req[2] ? addr : ~bus_err_addr;
			data_viol_addr <= req[4] ? addr : ~data_viol_addr;
		end
	end
endmodule : fsfs_core_model

// ### bench/fsfs_slice_tb_top.sv
// fault status slice bench: apb master, core model, queued apb result checks
// assumes fsfs_slice answers apb within a few cycles
`timescale 1ns/10ps
`include "fsfs_consts.svh"
module fsfs_slice_tb_top
	import fsfs_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	fsfs_word_t pwdata, prdata, addr, a, sp0, mma, bfa, spr;
	logic [5:0] req;
	logic ibp, iss, pbe, stv, dav, exe;
	fsfs_word_t bea, dva;
	logic [2:0] flags;
	logic [32:0] e;
	logic [32:0] expq[$];
	int n_fail, n_checks, seed;

	fsfs_slice i_fsfs_slice (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_bus_err_flag_err_prefetch(ibp), .instr_issue(iss), .precise_bus_err(pbe),
		.bus_err_addr(bea), .stack_violation(stv), .data_violation(dav),
		.data_viol_addr(dva), .exc_entry(exe), .instr_bus_err_flag(flags[2]),
		.mem_fault_addr_valid(flags[1]), .stacking_access_violation(flags[0]),
		.mem_fault_address_reg(mma), .bus_fault_address_reg(bfa), .stack_pointer(spr),
		.irq(irq));
	fsfs_core_model i_fsfs_core_model (.pclk(pclk), .presetn(presetn), .req(req),
		.addr(addr), .instr_bus_err_flag_err_prefetch(ibp), .instr_issue(iss), .precise_bus_err(pbe),
		.stack_violation(stv), .data_violation(dav), .exc_entry(exe),
		.bus_err_addr(bea), .data_viol_addr(dva));

	////////////////////////////////////////////////////////////////
	// shared compare, apb master and core request tasks
	task chk(input string nm, input logic [32:0] ex, input logic [32:0] g);
		n_checks++;
		if (g !== ex)
		begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, ex, g);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] ad, input fsfs_word_t d, input logic [32:0] ex);
		expq.push_back(ex);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task rd(input logic [11:0] ad, input fsfs_word_t ex);
		apb(1'b0, ad, 32'h0, {1'b0, ex});
	endtask : rd

	task wr(input logic [11:0] ad, input fsfs_word_t d);
		apb(1'b1, ad, d, 33'h0);
		repeat (2) @(posedge pclk);
	endtask : wr

	task core(input logic [5:0] m, input fsfs_word_t ad);
		req <= m;
		addr <= ad;
		@(posedge pclk);
		req <= 6'h0;
		repeat (5) @(posedge pclk);
	endtask : core

	task test_done;
		chk("queue", 33'h0, 33'(expq.size()));
		if (n_fail == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////
	// monitor: oldest note against each completed transfer; write data not compared
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1)
		begin
			e = expq.pop_front();
			chk("apb", pwrite ? {e[32], 32'h0} : e, {pslverr, pwrite ? 32'h0 : prdata});
		end

	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// watchdog well beyond the sequence length
	initial
	begin
		#(50 * 3000);
		n_fail++;
		test_done();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, req, addr} = '0;
		{n_fail, n_checks, seed} = {32'd0, 32'd0, 32'd29};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("flags", 3'h0, flags);
		rd(`FSFS_OFF_STATUS, `FSFS_RST_FLAGS);
		wr(`FSFS_OFF_IRQ_EN, 32'h7);
		a = $random(seed);
		core(6'h04, a);
		chk("bfaddr", a, bfa);
		core(6'h01, ~a);
		chk("flags", 3'h0, flags);
		core(6'h02, ~a);
		chk("flags", 3'h4, flags);
		chk("bfaddr", a, bfa);
		chk("irq", 1'b1, irq);
		rd(`FSFS_OFF_STATUS, 32'h100);
		wr(`FSFS_OFF_STATUS, 32'hffff_feff);
		chk("flags", 3'h4, flags);
		wr(`FSFS_OFF_STATUS, 32'h100);
		chk("flags", 3'h0, flags);
		wr(`FSFS_OFF_IRQ_CLR, 32'h1);
		chk("irq", 1'b0, irq);
		// stacking fault during entry: pointer still moves, no address capture
		sp0 = spr;
		core(6'h28, $random(seed));
		chk("flags", 3'h1, flags);
		chk("sp", {1'b0, sp0 - `FSFS_STK_FRAME}, spr);
		chk("mem_fault_address_reg", 32'h0, mma);
		rd(`FSFS_OFF_STATUS, 32'h10);
		a = $random(seed);
		core(6'h10, a);
		chk("flags", 3'h3, flags);
		rd(`FSFS_OFF_MEM_FAULT_ADDRESS_REG, a);
		rd(`FSFS_OFF_STATUS, 32'h90);
		wr(`FSFS_OFF_STATUS, 32'h100);
		chk("flags", 3'h3, flags);
		// masking, then status clear leaves the line low when re-enabled
		wr(`FSFS_OFF_IRQ_EN, 32'h0);
		chk("irq", 1'b0, irq);
		rd(`FSFS_OFF_IRQ_STAT, 32'h6);
		wr(`FSFS_OFF_IRQ_CLR, 32'h6);
		wr(`FSFS_OFF_IRQ_EN, 32'h7);
		chk("irq", 1'b0, irq);
		wr(`FSFS_OFF_STATUS, 32'hffff_ffff);
		chk("flags", 3'h0, flags);
		// violation in the stacking cycle: no capture, so no valid address either
		core(6'h18, ~a);
		chk("flags", 3'h1, flags);
		chk("mem_fault_address_reg", a, mma);
		wr(`FSFS_OFF_STATUS, 32'h10);
		rd(`FSFS_OFF_STATUS, 32'h0);
		apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
		test_done();
	end
endmodule : fsfs_slice_tb_top
